//--- verilog/sre_consts.svh
// Purpose: Shared constants for the two-wire register and nonvolatile link
// Assumes: Included by bare name from the device and host files
// Notes: Times are in microseconds; cycle counts derive from the clock
`ifndef SRE_CONSTS_SVH
`define SRE_CONSTS_SVH
`define SRE_CLK_MHZ 25
`define SRE_DL_US 1000
`define SRE_ERASE_US 20000
`define SRE_PROG_US 250
`define SRE_TOUT_US 30000
`define SRE_FETCH_US 10
`define SRE_ADDR_TOP 5'h05
`define SRE_CMD_ERASE 8'hfe
`define SRE_CMD_BLOCK 8'hfc
`define SRE_EE_HI_MIN 8'hf8
`define SRE_EE_HI_MAX 8'hfb
`define SRE_EE_PREFIX 6'h3e
`define SRE_RAM_TOP 8'hdf
`define SRE_RAM_BYTES 224
`define SRE_EE_BYTES 1024
`define SRE_REG_RELOAD 8'hd8
`define SRE_REG_UPDCTL 8'h90
`define SRE_REG_MAKER 8'hf4
`define SRE_REG_REV 8'hf5
`define SRE_REG_BRAND1 8'hf6
`define SRE_REG_BRAND2 8'hf7
`define SRE_ERASE_EN_BIT 2
`define SRE_RELOAD_BIT 0
`define SRE_PAGE_BYTES 32
`define SRE_STATE_BASE 10'h200
`define SRE_STATE_LAST 6'h3e
`define SRE_CAPTURE_CYC 3
`define SRE_HOST_CTRL 8'h00
`define SRE_HOST_STAT 8'h04
`define SRE_HOST_QTR 4
`define SRE_FLUSH_BITS 16
`endif

//--- verilog/sre_pkg.sv
// Purpose: Types shared by both ends of the link
// Assumes: Constants come from sre_consts.svh
// Notes: Command codes are what software writes to the host
package sre_pkg;
   typedef enum {DEV_IDLE, DEV_ADDR, DEV_RX, DEV_TX} sre_dev_state_t;
   typedef enum logic [2:0] {
      CMD_NOP = 3'h0,
      CMD_START = 3'h1,
      CMD_STOP = 3'h2,
      CMD_WRITE = 3'h3,
      CMD_READ = 3'h4,
      CMD_FLUSH = 3'h5
   } sre_cmd_t;
endpackage : sre_pkg

//--- verilog/sre_if.sv
// Purpose: Open-drain two-wire link joining host and device
// Assumes: Each party drives out, enable, and reads the resolved level
// Notes: Wired-AND; an undriven line floats high through the pull-up
`timescale 1ns/1ns
interface sre_if;
   logic sclHostOut;
   logic sclHostOe;
   logic sdaHostOut;
   logic sdaHostOe;
   logic sclDevOut;
   logic sclDevOe;
   logic sdaDevOut;
   logic sdaDevOe;
   logic sclIn;
   logic sdaIn;
   // Line level resolved from the four drivers
   assign sclIn = !(sclHostOe && !sclHostOut) && !(sclDevOe && !sclDevOut);
   assign sdaIn = !(sdaHostOe && !sdaHostOut) && !(sdaDevOe && !sdaDevOut);
   modport host(output sclHostOut, output sclHostOe, output sdaHostOut,
      output sdaHostOe, input sclIn, input sdaIn);
   modport dev(output sclDevOut, output sclDevOe, output sdaDevOut,
      output sdaDevOe, input sclIn, input sdaIn);
endinterface : sre_if

//--- verilog/sre_sync.sv
// Purpose: Two-flop synchroniser for a group of asynchronous inputs
// Assumes: Inputs are levels from outside the sys_clk domain
// Notes: First stage is read only by the second stage
`timescale 1ns/1ns
module sre_sync #(
   parameter int W = 2
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] syncOut
);
   logic [W-1:0] stage1_reg;
   if (W < 1) $error("sre_sync needs at least one bit");
   // Reset high to match idle open-drain lines
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         stage1_reg <= '1;
         syncOut <= '1;
      end
      else
      begin
         stage1_reg <= asyncIn;
         syncOut <= stage1_reg;
      end
   end
endmodule : sre_sync

//--- verilog/sre_device.sv
// Purpose: Two-wire slave front end with registers and nonvolatile cells
// Assumes: sys_clk 25 MHz; link pins asynchronous and synchronised here
// Notes: Nonvolatile cells are modelled as arrays with busy timers
// Summary of operation
// - State cell holds 63 words of 64 bits
// - Fetch first word, next on advance, 10us
// - Host rewrites state words directly in cell
// - First write byte loads the address pointer; commands 0xfe and 0xfc leave it unchanged
// - Both cells mapped at 0xf800 to 0xfbff
// - Host programs only blank, erased locations; the device writes any cell location without a blank check
// - Config cell: 16 pages, 0-6 mirror registers
// - Copy pages 0-6 at power-up and reload
// - Refuse bus access during 1 ms download
// - Slave address 00101 plus two select pins
// - Identification registers readable at 0xf4-0xf7
// - Start then seven address bits and direction
// - Matched device pulls data low for ack
// - Nine clocks per byte, data changes low
// - First write byte is command or address
// - Master ends with stop, read with nack
// - Clock held low 30 ms aborts transfer
// - Clock flush releases a stuck data line
// - Command 0xfe erases page when enabled
// - Nack every access during 20 ms erase
// - Command 0xfc then count then data bytes
// - Stretch clock while a byte programs
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ns
`include "sre_consts.svh"
module sre_device #(
   parameter int DL_CYC = `SRE_DL_US * `SRE_CLK_MHZ,
   parameter int ERASE_CYC = `SRE_ERASE_US * `SRE_CLK_MHZ,
   parameter int PROG_CYC = `SRE_PROG_US * `SRE_CLK_MHZ,
   parameter int TOUT_CYC = `SRE_TOUT_US * `SRE_CLK_MHZ,
   parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
   parameter logic [7:0] REV_CODE = 8'h3c, // Arbitrary value
   parameter logic [7:0] BRAND_ONE = 8'h11, // Arbitrary value
   parameter logic [7:0] BRAND_TWO = 8'h22 // Arbitrary value
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   sre_if.dev link,
   input wire logic addr_select_high,
   input wire logic addr_select_low,
   input wire logic stateAdvance,
   output logic [63:0] stateWord,
   output logic [5:0] stateIndex,
   output logic configReady
);
   localparam int FETCH_CYC = `SRE_FETCH_US * `SRE_CLK_MHZ;
   if (DL_CYC < 2 * `SRE_RAM_BYTES || ERASE_CYC < 2 * `SRE_PAGE_BYTES)
      $error("download or erase time too short for the copy loops");
   if (PROG_CYC < 1 || TOUT_CYC < 1)
      $error("timer counts must be positive");

   logic [7:0] ram [0:`SRE_RAM_BYTES-1];
   logic [7:0] ee [0:`SRE_EE_BYTES-1];
   logic [3:0] pinS;
   logic sclS, sdaS, sclD, sdaD, sclRise, sclFall, startDet, stopDet;
   sre_pkg::sre_dev_state_t state_reg;
   logic [3:0] bitCnt_reg;
   logic [7:0] shift_reg, outShift_reg, rdData;
   logic [15:0] ptr_reg;
   logic [7:0] wrData_reg;
   logic [15:0] wrAddr_reg;
   logic wrStb_reg, eraseStb_reg, reloadStb_reg, isRead_reg, mAck_reg;
   logic cmdSeen_reg, wantLow_reg, wantCount_reg, stretch_reg;
   logic [1:0] addrSel_reg;
   logic [31:0] dlCnt_reg, eraseCnt_reg, progCnt_reg, toutCnt_reg;
   logic [31:0] fetchCnt_reg;
   logic [8:0] copyIdx_reg;
   logic copying_reg, fetching_reg;
   logic dlBusy, eraseBusy, progBusy;

   // Address decode shared by read and write paths
   function automatic logic isEe(input logic [15:0] a);
      isEe = (a[15:10] == `SRE_EE_PREFIX);
   endfunction : isEe

   sre_sync #(.W(4)) uSync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .asyncIn({link.sclIn, link.sdaIn, addr_select_high, addr_select_low}),
      .syncOut(pinS)
   );
   assign sclS = pinS[3];
   assign sdaS = pinS[2];
   assign dlBusy = (dlCnt_reg < DL_CYC) || copying_reg;
   assign eraseBusy = (eraseCnt_reg != 32'h0);
   assign progBusy = (progCnt_reg != 32'h0);
   // Edge and condition detection on synchronised lines
   assign sclRise = sclS && !sclD;
   assign sclFall = !sclS && sclD;
   assign startDet = sclS && sclD && sdaD && !sdaS;
   assign stopDet = sclS && sclD && !sdaD && sdaS;
   assign link.sclDevOut = 1'b0;
   assign link.sdaDevOut = 1'b0;
   assign link.sclDevOe = stretch_reg;
   assign configReady = !dlBusy;

   // Read multiplexer; unmapped addresses read as zero
   always_comb
   begin
      rdData = 8'h00;
      if (isEe(ptr_reg))
         rdData = ee[ptr_reg[9:0]];
      else if (ptr_reg[15:8] == 8'h00)
      begin
         if (ptr_reg[7:0] <= `SRE_RAM_TOP)
            rdData = ram[ptr_reg[7:0]];
         unique case (ptr_reg[7:0])
            `SRE_REG_MAKER: rdData = MAKER_CODE;
            `SRE_REG_REV: rdData = REV_CODE;
            `SRE_REG_BRAND1: rdData = BRAND_ONE;
            `SRE_REG_BRAND2: rdData = BRAND_TWO;
            default: ;
         endcase
      end
   end

   // Delayed line copies for edge detection
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         sclD <= 1'b1;
         sdaD <= 1'b1;
      end
      else
      begin
         sclD <= sclS;
         sdaD <= sdaS;
      end
   end

   // Power-up timer, select-pin capture and page 0-6 copy
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         dlCnt_reg <= 32'h0;
         addrSel_reg <= 2'b00;
         copying_reg <= 1'b1;
         copyIdx_reg <= 9'h0;
      end
      else
      begin
         if (dlCnt_reg < DL_CYC)
            dlCnt_reg <= dlCnt_reg + 32'h1;
         if (dlCnt_reg == `SRE_CAPTURE_CYC)
            addrSel_reg <= pinS[1:0];
         if (reloadStb_reg)
         begin
            copying_reg <= 1'b1;
            copyIdx_reg <= 9'h0;
         end
         else if (copying_reg)
         begin
            copyIdx_reg <= copyIdx_reg + 9'h1;
            if (copyIdx_reg == 9'(`SRE_RAM_BYTES - 1))
               copying_reg <= 1'b0;
         end
      end
   end

   // Volatile registers: bus writes and download copy
   always_ff @(posedge sys_clk)
   begin
      if (copying_reg)
         ram[copyIdx_reg[7:0]] <= ee[copyIdx_reg];
      else if (wrStb_reg && wrAddr_reg[15:8] == 8'h00 &&
         wrAddr_reg[7:0] <= `SRE_RAM_TOP &&
         wrAddr_reg[7:0] != `SRE_REG_RELOAD)
         ram[wrAddr_reg[7:0]] <= wrData_reg;
   end

   // Nonvolatile cells: byte program and page erase to all ones
   always_ff @(posedge sys_clk)
   begin
      if (eraseBusy && eraseCnt_reg <= `SRE_PAGE_BYTES)
         ee[{ptr_reg[9:5], 5'(eraseCnt_reg - 32'h1)}] <= 8'hff;
      else if (wrStb_reg && isEe(wrAddr_reg))
         ee[wrAddr_reg[9:0]] <= wrData_reg;
   end

   // Erase and program busy timers
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         eraseCnt_reg <= 32'h0;
         progCnt_reg <= 32'h0;
      end
      else
      begin
         if (eraseStb_reg)
            eraseCnt_reg <= ERASE_CYC;
         else if (eraseBusy)
            eraseCnt_reg <= eraseCnt_reg - 32'h1;
         if (wrStb_reg && isEe(wrAddr_reg))
            progCnt_reg <= PROG_CYC;
         else if (progBusy)
            progCnt_reg <= progCnt_reg - 32'h1;
      end
   end

   // State stepper: one 64-bit word per state, index 63 kept reserved
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         stateWord <= 64'h0;
         stateIndex <= 6'h0;
         fetching_reg <= 1'b0;
         fetchCnt_reg <= 32'h0;
      end
      else if (fetching_reg)
      begin
         fetchCnt_reg <= fetchCnt_reg + 32'h1;
         if (fetchCnt_reg == FETCH_CYC - 1)
         begin
            fetching_reg <= 1'b0;
            for (int k = 0; k < 8; k++)
               stateWord[8*k +: 8] <=
                  ee[`SRE_STATE_BASE + {1'b0, stateIndex, 3'(k)}];
         end
      end
      else if (dlCnt_reg == DL_CYC - 1 || (configReady && stateAdvance))
      begin
         fetching_reg <= 1'b1;
         fetchCnt_reg <= 32'h0;
         if (dlCnt_reg == DL_CYC && !copying_reg)
            stateIndex <= (stateIndex == `SRE_STATE_LAST) ? 6'h0 :
               stateIndex + 6'h1;
      end
   end

   // Bit and byte protocol engine
   always_ff @(posedge sys_clk)
   begin
      wrStb_reg <= 1'b0;
      eraseStb_reg <= 1'b0;
      reloadStb_reg <= 1'b0;
      if (!reset_n)
      begin
         state_reg <= sre_pkg::DEV_IDLE;
         bitCnt_reg <= 4'h0;
         shift_reg <= 8'h0;
         outShift_reg <= 8'h0;
         ptr_reg <= 16'h0;
         wrData_reg <= 8'h0;
         wrAddr_reg <= 16'h0;
         isRead_reg <= 1'b0;
         mAck_reg <= 1'b1;
         cmdSeen_reg <= 1'b0;
         wantLow_reg <= 1'b0;
         wantCount_reg <= 1'b0;
         stretch_reg <= 1'b0;
         toutCnt_reg <= 32'h0;
         link.sdaDevOe <= 1'b0;
      end
      else if (startDet)
      begin
         state_reg <= sre_pkg::DEV_ADDR;
         bitCnt_reg <= 4'h0;
         link.sdaDevOe <= 1'b0;
         toutCnt_reg <= 32'h0;
      end
      else if (stopDet || toutCnt_reg >= TOUT_CYC)
      begin
         state_reg <= sre_pkg::DEV_IDLE;
         link.sdaDevOe <= 1'b0;
         stretch_reg <= 1'b0;
         toutCnt_reg <= 32'h0;
      end
      else
      begin
         if (stretch_reg && !progBusy)
            stretch_reg <= 1'b0;
         if (state_reg == sre_pkg::DEV_IDLE || sclS || stretch_reg)
            toutCnt_reg <= 32'h0;
         else
            toutCnt_reg <= toutCnt_reg + 32'h1;
         if (sclRise && state_reg != sre_pkg::DEV_IDLE)
         begin
            bitCnt_reg <= bitCnt_reg + 4'h1;
            if (bitCnt_reg < 4'h8)
               shift_reg <= {shift_reg[6:0], sdaS};
            else
               mAck_reg <= sdaS;
         end
         if (sclFall && state_reg != sre_pkg::DEV_IDLE)
         begin
            if (bitCnt_reg == 4'h8)
            begin
               unique case (state_reg)
                  sre_pkg::DEV_ADDR:
                  begin
                     if (shift_reg[7:1] == {`SRE_ADDR_TOP, addrSel_reg} &&
                        !dlBusy && !eraseBusy)
                     begin
                        link.sdaDevOe <= 1'b1;
                        isRead_reg <= shift_reg[0];
                        cmdSeen_reg <= 1'b0;
                        wantLow_reg <= 1'b0;
                        wantCount_reg <= 1'b0;
                     end
                     else
                        state_reg <= sre_pkg::DEV_IDLE;
                  end
                  sre_pkg::DEV_RX:
                  begin
                     link.sdaDevOe <= 1'b1;
                     cmdSeen_reg <= 1'b1;
                     if (!cmdSeen_reg)
                     begin
                        if (shift_reg == `SRE_CMD_ERASE)
                           eraseStb_reg <=
                              ram[`SRE_REG_UPDCTL][`SRE_ERASE_EN_BIT];
                        else if (shift_reg == `SRE_CMD_BLOCK)
                           wantCount_reg <= 1'b1;
                        else if (shift_reg >= `SRE_EE_HI_MIN &&
                           shift_reg <= `SRE_EE_HI_MAX)
                        begin
                           ptr_reg[15:8] <= shift_reg;
                           wantLow_reg <= 1'b1;
                        end
                        else
                           ptr_reg <= {8'h00, shift_reg};
                     end
                     else if (wantLow_reg)
                     begin
                        ptr_reg[7:0] <= shift_reg;
                        wantLow_reg <= 1'b0;
                     end
                     else if (wantCount_reg)
                        wantCount_reg <= 1'b0;
                     else
                     begin
                        wrStb_reg <= 1'b1;
                        wrAddr_reg <= ptr_reg;
                        wrData_reg <= shift_reg;
                        reloadStb_reg <= (ptr_reg == {8'h00,
                           `SRE_REG_RELOAD}) && shift_reg[`SRE_RELOAD_BIT];
                        ptr_reg <= ptr_reg + 16'h1;
                     end
                  end
                  default: link.sdaDevOe <= 1'b0;
               endcase
            end
            else if (bitCnt_reg == 4'h9)
            begin
               link.sdaDevOe <= 1'b0;
               bitCnt_reg <= 4'h0;
               if (state_reg == sre_pkg::DEV_RX && progBusy)
                  stretch_reg <= 1'b1;
               if (state_reg == sre_pkg::DEV_ADDR)
                  state_reg <= isRead_reg ? sre_pkg::DEV_TX :
                     sre_pkg::DEV_RX;
               if ((state_reg == sre_pkg::DEV_ADDR && isRead_reg) ||
                  (state_reg == sre_pkg::DEV_TX && !mAck_reg))
               begin
                  state_reg <= sre_pkg::DEV_TX;
                  outShift_reg <= rdData;
                  link.sdaDevOe <= !rdData[7];
                  ptr_reg <= ptr_reg + 16'h1;
               end
               else if (state_reg == sre_pkg::DEV_TX)
                  state_reg <= sre_pkg::DEV_IDLE;
            end
            else if (state_reg == sre_pkg::DEV_TX)
            begin
               outShift_reg <= {outShift_reg[6:0], 1'b0};
               link.sdaDevOe <= !outShift_reg[6];
            end
         end
      end
   end
endmodule : sre_device

//--- verilog/sre_host.sv
// Purpose: Two-wire bus master driven by software over AHB-Lite
// Assumes: Single sys_clk; zero-wait slave; whole-word accesses only
// Notes: One command (start, stop, byte, flush) at a time
`timescale 1ns/1ns
`include "sre_consts.svh"
module sre_host #(
   parameter int QTR_CYC = `SRE_HOST_QTR
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   sre_if.host link,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata
);
   if (QTR_CYC < 4) $error("quarter bit must allow input sync delay");
   logic [1:0] lineS;
   logic [7:0] dAddr_reg;
   logic dWrite_reg, busy_reg, go_reg, ackIn_reg;
   sre_pkg::sre_cmd_t cmd_reg, goCmd_reg;
   logic [7:0] goData_reg, rxData_reg;
   logic goAck_reg;
   logic [15:0] bits_reg;
   logic [8:0] rx_reg;
   logic [4:0] bitsLeft_reg;
   logic [2:0] phase_reg;
   logic [7:0] div_reg;
   logic qTick;

   sre_sync #(.W(2)) uSync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .asyncIn({link.sclIn, link.sdaIn}),
      .syncOut(lineS)
   );
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign link.sclHostOut = 1'b0;
   assign link.sdaHostOut = 1'b0;
   assign qTick = (div_reg == 8'(QTR_CYC - 1));

   // Bus slave: latch address phase, act in data phase
   always_ff @(posedge sys_clk)
   begin
      go_reg <= 1'b0;
      if (!reset_n)
      begin
         dAddr_reg <= 8'h0;
         dWrite_reg <= 1'b0;
         hrdata <= 32'h0;
         goCmd_reg <= sre_pkg::CMD_NOP;
         goData_reg <= 8'h0;
         goAck_reg <= 1'b0;
      end
      else
      begin
         if (hsel && htrans[1] && hready)
         begin
            dAddr_reg <= haddr[7:0];
            dWrite_reg <= hwrite;
            hrdata <= (haddr[7:0] == `SRE_HOST_STAT) ?
               {16'h0, rxData_reg, 6'h0, ackIn_reg, busy_reg} : 32'h0;
         end
         else
            dWrite_reg <= 1'b0;
         if (dWrite_reg && dAddr_reg == `SRE_HOST_CTRL && !busy_reg)
         begin
            go_reg <= 1'b1;
            goCmd_reg <= sre_pkg::sre_cmd_t'(hwdata[2:0]);
            goData_reg <= hwdata[15:8];
            goAck_reg <= hwdata[16];
         end
      end
   end

   // Quarter-bit divider, held while SCL is stretched low
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n || qTick || !busy_reg)
         div_reg <= 8'h0;
      else if (!(phase_reg == 3'h2 && !lineS[1]))
         div_reg <= div_reg + 8'h1;
   end

   // Line sequencer for start, stop and bit groups
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         busy_reg <= 1'b0;
         cmd_reg <= sre_pkg::CMD_NOP;
         bits_reg <= 16'hffff;
         rx_reg <= 9'h0;
         bitsLeft_reg <= 5'h0;
         phase_reg <= 3'h0;
         rxData_reg <= 8'h0;
         ackIn_reg <= 1'b0;
         link.sclHostOe <= 1'b0;
         link.sdaHostOe <= 1'b0;
      end
      else if (go_reg)
      begin
         busy_reg <= (goCmd_reg != sre_pkg::CMD_NOP);
         cmd_reg <= goCmd_reg;
         phase_reg <= 3'h0;
         bitsLeft_reg <= (goCmd_reg == sre_pkg::CMD_FLUSH) ?
            5'(`SRE_FLUSH_BITS) : 5'h9;
         if (goCmd_reg == sre_pkg::CMD_WRITE)
            bits_reg <= {goData_reg, 1'b1, 7'h7f};
         else
            bits_reg <= {8'hff, !goAck_reg, 7'h7f};
      end
      else if (busy_reg && qTick)
      begin
         phase_reg <= phase_reg + 3'h1;
         unique case (cmd_reg)
            sre_pkg::CMD_START:
            begin
               unique case (phase_reg)
                  3'h0: link.sdaHostOe <= 1'b0;
                  3'h1: link.sclHostOe <= 1'b0;
                  3'h2: link.sdaHostOe <= 1'b1;
                  default:
                  begin
                     link.sclHostOe <= 1'b1;
                     busy_reg <= 1'b0;
                  end
               endcase
            end
            sre_pkg::CMD_STOP:
            begin
               unique case (phase_reg)
                  3'h0: link.sdaHostOe <= 1'b1;
                  3'h1: link.sclHostOe <= 1'b0;
                  3'h2: link.sdaHostOe <= 1'b0;
                  default: busy_reg <= 1'b0;
               endcase
            end
            sre_pkg::CMD_WRITE, sre_pkg::CMD_READ, sre_pkg::CMD_FLUSH:
            begin
               unique case (phase_reg)
                  3'h0: link.sdaHostOe <= !bits_reg[15];
                  3'h1: link.sclHostOe <= 1'b0;
                  3'h2: rx_reg <= {rx_reg[7:0], lineS[0]};
                  default:
                  begin
                     link.sclHostOe <= 1'b1;
                     phase_reg <= 3'h0;
                     bits_reg <= {bits_reg[14:0], 1'b1};
                     bitsLeft_reg <= bitsLeft_reg - 5'h1;
                     if (bitsLeft_reg == 5'h1)
                     begin
                        busy_reg <= 1'b0;
                        rxData_reg <= rx_reg[8:1];
                        ackIn_reg <= rx_reg[0];
                     end
                  end
               endcase
            end
            default: busy_reg <= 1'b0;
         endcase
      end
   end
endmodule : sre_host

//--- tb/sre_sva.sv
// Purpose: Protocol checks on the two-wire link
// Assumes: One sys_clk domain; lines are wired-AND
// Notes: Bounds scale with the shortened counts
`timescale 1ns/1ns
module sre_sva #(
   parameter int DL_CYC = 600,
   parameter int PROG_CYC = 50
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic sclHostOe,
   input wire logic sdaHostOe,
   input wire logic sclDevOe,
   input wire logic sdaDevOe,
   input wire logic sclIn
);
   int upCnt;
   int holdCnt;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // Age since reset; length of a clock stretch
   always_ff @(posedge sys_clk)
   begin
      upCnt <= !reset_n ? 0 : upCnt + int'(upCnt < DL_CYC);
      holdCnt <= (reset_n && sclDevOe) ? holdCnt + 1 : 0;
   end
   a_dl_quiet: assert property (upCnt < DL_CYC |-> !sdaDevOe)
      else $error("ack during download");
   a_ack_low_phase: assert property ($rose(sdaDevOe) |-> !sclIn)
      else $error("data pulled while clock high");
   a_ack_holds: assert property ($rose(sdaDevOe) |-> sdaDevOe[*4])
      else $error("data pull too short");
   a_sda_hold_high: assert property ($fell(sdaDevOe) |-> !sclIn)
      else $error("data released while clock high");
   a_start_clocks: assert property ($rose(sdaHostOe) && sclIn
      |-> ##[1:12] sclHostOe) else $error("start not followed by clock");
   a_stretch_low: assert property ($rose(sclDevOe) |-> !sclIn)
      else $error("stretch began with clock high");
   a_stretch_bound: assert property (holdCnt <= PROG_CYC + 100)
      else $error("stretch too long");
   a_stretch_ack: assert property ($rose(sclDevOe) |-> $past(sdaDevOe, 4))
      else $error("stretch without prior ack");
   // Main traffic seen
   c_ack: cover property ($rose(sdaDevOe));
   c_stretch: cover property ($rose(sclDevOe));
   c_start: cover property ($rose(sdaHostOe) && sclIn);
endmodule : sre_sva

//--- tb/tb.sv
// Purpose: Host and device joined, host driven over AHB-Lite
// Assumes: Select pins give slave address 0x16
// Notes: Short counts keep the run brief
`timescale 1ns/1ns
module tb;
   localparam int DL = 600;
   localparam int PG = 50;
   localparam logic [7:0] ID [4] = '{8'h5a, 8'h3c, 8'h11, 8'h22};
   logic sys_clk = 1'h0, reset_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
   logic stateAdvance = 1'h0, hreadyout, configReady;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [5:0] stateIndex;
   logic [63:0] stateWord;
   int n_errors = 0;
   int comparisons = 0;
   sre_if link ();
   sre_host sre_host_i (.sys_clk, .reset_n, .link(link.host), .hsel, .haddr,
      .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
      .hresp(), .hrdata);
   sre_device #(.DL_CYC(DL), .ERASE_CYC(200), .PROG_CYC(PG), .TOUT_CYC(2000),
      .MAKER_CODE(ID[0]), .REV_CODE(ID[1]), .BRAND_ONE(ID[2]),
      .BRAND_TWO(ID[3])) sre_device_i (.sys_clk, .reset_n, .link(link.dev),
      .addr_select_high(1'h1), .addr_select_low(1'h0), .stateAdvance,
      .stateWord, .stateIndex, .configReady);
   sre_sva #(.DL_CYC(DL), .PROG_CYC(PG)) sre_sva_i (.sys_clk, .reset_n,
      .sclHostOe(link.sclHostOe), .sdaHostOe(link.sdaHostOe),
      .sclDevOe(link.sclDevOe), .sdaDevOe(link.sdaDevOe), .sclIn(link.sclIn));
   initial forever #20 sys_clk = ~sys_clk;
   task automatic chk(input logic ok, input string m);
      comparisons++;
      if (ok !== 1'h1)
         $display("mismatch %0t %s", $time, m);
      n_errors += int'(ok !== 1'h1);
   endtask : chk
   // One AHB single transfer; read data taken at the data-phase edge
   task automatic bus(input logic w, input logic [31:0] a, d);
      hsel <= 1'h1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge sys_clk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'h1);
      rd = hrdata;
   endtask : bus
   // Issue a link command, then poll until the host is idle
   task automatic sd(input logic [2:0] c, input logic [7:0] d, input logic a);
      bus(1'h1, 32'h0, {15'h0, a, d, 5'h0, c});
      @(posedge sys_clk); // Busy lags the go pulse by a cycle
      do bus(1'h0, 32'h4, 32'h0); while (rd[0] !== 1'h0);
   endtask : sd
   task automatic wb(input logic [7:0] d, input logic n);
      sd(3'h3, d, 1'h0);
      chk(rd[1] === n, "acknowledge");
   endtask : wb
   task automatic rb(input logic a, input logic [7:0] e);
      sd(3'h4, 8'h0, a);
      chk(rd[15:8] === e, "read data");
   endtask : rb
   task automatic wr(input logic [7:0] c);
      sd(3'h1, 8'h0, 1'h0);
      wb(8'h2c, 1'h0);
      wb(c, 1'h0);
   endtask : wr
   task automatic rdst;
      sd(3'h2, 8'h0, 1'h0);
      sd(3'h1, 8'h0, 1'h0);
      wb(8'h2d, 1'h0);
   endtask : rdst
   task automatic t_early;
      sd(3'h1, 8'h0, 1'h0);
      wb(8'h2c, 1'h1);
      sd(3'h2, 8'h0, 1'h0);
   endtask : t_early
   task automatic t_addr;
      sd(3'h1, 8'h0, 1'h0);
      wb(8'h28, 1'h1);
      sd(3'h2, 8'h0, 1'h0);
   endtask : t_addr
   task automatic t_ram;
      wr(8'h10);
      wb(8'ha5, 1'h0);
      wr(8'h10);
      rdst();
      rb(1'h0, 8'ha5);
      sd(3'h2, 8'h0, 1'h0);
   endtask : t_ram
   task automatic t_id;
      wr(8'hf4);
      rdst();
      for (int i = 0; i < 4; i++) rb(i < 3, ID[i]);
      sd(3'h2, 8'h0, 1'h0);
   endtask : t_id
   // Program one cell byte, then read it back through the pointer
   task automatic t_ee;
      wr(8'hf9);
      wb(8'h20, 1'h0);
      wb(8'h3c, 1'h0);
      wr(8'hf9);
      wb(8'h20, 1'h0);
      rdst();
      rb(1'h0, 8'h3c);
      sd(3'h2, 8'h0, 1'h0);
   endtask : t_ee
   // Block-write state word 1 into the cell, then step into it
   task automatic t_step;
      wr(8'hfa);
      wb(8'h08, 1'h0);
      wr(8'hfc);
      wb(8'h08, 1'h0);
      for (int i = 0; i < 8; i++) wb(8'(i + 1), 1'h0);
      sd(3'h2, 8'h0, 1'h0);
      stateAdvance <= 1'h1;
      @(posedge sys_clk);
      stateAdvance <= 1'h0;
      repeat (300) @(posedge sys_clk);
      chk(stateIndex === 6'h1, "state index");
      chk(stateWord === 64'h0807060504030201, "state word");
   endtask : t_step
   task automatic report_and_stop;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   // Hang guard, well beyond the expected run
   initial
   begin
      repeat (90000) @(posedge sys_clk);
      n_errors++;
      report_and_stop();
   end
   // Main sequence
   initial
   begin
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'h1;
      @(posedge sys_clk);
      t_early();
      while (configReady !== 1'h1) @(posedge sys_clk);
      t_addr();
      t_ram();
      t_id();
      t_ee();
      t_step();
      report_and_stop();
   end
endmodule : tb
